// ### hw/uenak_ctrl.sv
// Purpose: endpoint0 NAK control with AXI4-Lite register access
// Assumes: usb events are single-cycle pulses on ref_clk
// Notes: fifo-clear effects are delayed five clocks
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
module uenak_ctrl
   import uenak_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // axi4-lite slave
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // usb side events
   input  wire logic        outDataOk,
   input  wire logic        rxCountZero,
   input  wire logic        txAcked,
   input  wire logic        txBufFull,
   input  wire logic        shortDataEnd,
   input  wire logic        nakSendingEp0RdEp2,
   input  wire logic        autoRequest,
   output      logic        outNakReply,
   output      logic        ep0RxClear,
   output      logic        ep0TxClear,
   output      logic        ep0OutNak,
   output      logic        ep0InNak
);
   logic        awHeld_ff, wHeld_ff;
   logic [15:0] awAddr_ff;
   logic [31:0] wData_ff;
   logic [3:0]  wStrb_ff;
   logic        bValid_ff, rValid_ff;
   logic [1:0]  bResp_ff, rResp_ff;
   logic [31:0] rData_ff;
   logic        outNak_ff, inNak_ff;
   logic        doWrite;
   logic        wrNak, wrFifo;
   logic [1:0]  clrDelayed;

   // ----------------------------------------
   // axi write channel
   // ----------------------------------------
   // address and data taken in either order; one write outstanding
   assign s_axi_awready = !awHeld_ff && !bValid_ff;
   assign s_axi_wready  = !wHeld_ff && !bValid_ff;
   assign doWrite       = awHeld_ff && wHeld_ff && !bValid_ff;
   assign wrNak  = doWrite && awAddr_ff == ENDPOINT0_NAK_CONTROL_OFFS && wStrb_ff[0];
   assign wrFifo = doWrite && awAddr_ff == FIFO_CLEAR_OFFS && wStrb_ff[0];

   // capture write address
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         awHeld_ff <= 1'b0;
         awAddr_ff <= 16'h0000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         awHeld_ff <= 1'b1;
         awAddr_ff <= s_axi_awaddr;
      end
      else if (doWrite)
         awHeld_ff <= 1'b0;
   end

   // capture write data
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wHeld_ff <= 1'b0;
         wData_ff <= 32'h0000_0000;
         wStrb_ff <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         wHeld_ff <= 1'b1;
         wData_ff <= s_axi_wdata;
         wStrb_ff <= s_axi_wstrb;
      end
      else if (doWrite)
         wHeld_ff <= 1'b0;
   end

   // write response; unmapped addresses get slverr
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bValid_ff <= 1'b0;
         bResp_ff  <= RESP_OKAY;
      end
      else if (doWrite)
      begin
         bValid_ff <= 1'b1;
         bResp_ff  <= (awAddr_ff == ENDPOINT0_NAK_CONTROL_OFFS ||
                       awAddr_ff == FIFO_CLEAR_OFFS) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bValid_ff <= 1'b0;
   end

   assign s_axi_bvalid = bValid_ff;
   assign s_axi_bresp  = bResp_ff;

   // ----------------------------------------
   // axi read channel
   // ----------------------------------------
   assign s_axi_arready = !rValid_ff;

   // read data; upper bits of the nak register read zero
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rValid_ff <= 1'b0;
         rData_ff  <= 32'h0000_0000;
         rResp_ff  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rValid_ff <= 1'b1;
         rResp_ff  <= RESP_OKAY;
         rData_ff  <= 32'h0000_0000;
         if (s_axi_araddr == ENDPOINT0_NAK_CONTROL_OFFS)
            rData_ff <= {30'h0, outNak_ff, inNak_ff};
         else if (s_axi_araddr != FIFO_CLEAR_OFFS)
            rResp_ff <= RESP_SLVERR;
      end
      else if (s_axi_rready)
         rValid_ff <= 1'b0;
   end

   assign s_axi_rvalid = rValid_ff;
   assign s_axi_rdata  = rData_ff;
   assign s_axi_rresp  = rResp_ff;

   // ----------------------------------------
   // fifo clear delay
   // ----------------------------------------
   // firmware must still wait before trusting status reads
   uenak_delay_line #(.WIDTH(2), .DEPTH(CLEAR_DELAY_CLKS)) uDelay
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .dIn     ({wrFifo && wData_ff[FIFO_CLR_TX_BIT], wrFifo && wData_ff[FIFO_CLR_RX_BIT]}),
      .dOut    (clrDelayed)
   );

   assign ep0RxClear = clrDelayed[0];
   assign ep0TxClear = clrDelayed[1];

   // ----------------------------------------
   // nak flags
   // ----------------------------------------
   // out nak: hardware set wins over any clear in the same cycle
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         outNak_ff <= 1'b0;
      else if (outDataOk)
         outNak_ff <= 1'b1;
      else if (wrNak && !nakSendingEp0RdEp2)
         outNak_ff <= wData_ff[OUT_NAK_BIT];
      else if (clrDelayed[0])
         outNak_ff <= 1'b0;
      else if (rxCountZero)
         outNak_ff <= 1'b0;
   end

   // in nak: set on full or short packet end; cleared on host ack or delayed tx fifo clear
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         inNak_ff <= 1'b0;
      else if (txBufFull || shortDataEnd)
         inNak_ff <= 1'b1;
      else if (txAcked || clrDelayed[1])
         inNak_ff <= 1'b0;
   end

   // automatic requests bypass the out nak flag
   assign outNakReply = outNak_ff && !autoRequest;
   assign ep0OutNak   = outNak_ff;
   assign ep0InNak    = inNak_ff;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence sFifoRx;
      wrFifo && wData_ff[FIFO_CLR_RX_BIT];
   endsequence

   a_clear_delay_five: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sFifoRx |-> ##5 ep0RxClear)
      else $error("rx clear not seen five clocks later");
   a_clear_not_early: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sFifoRx |=> !ep0RxClear [*4] ##1 ep0RxClear)
      else $error("rx clear early");
   a_write_ignored_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wrNak && nakSendingEp0RdEp2 && !outDataOk && !clrDelayed[0] && !rxCountZero
      |=> $stable(outNak_ff))
      else $error("out nak write not ignored");
   a_out_set_data: assert property (@(posedge ref_clk) disable iff (sys_rst)
      outDataOk |=> ep0OutNak)
      else $error("out nak not set on data");
   a_out_zero_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rxCountZero && !outDataOk && !wrNak |=> !ep0OutNak)
      else $error("out nak not cleared on zero count");
   a_reply_follows_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !autoRequest |-> outNakReply == ep0OutNak)
      else $error("nak reply mismatch");
   a_fw_hold_nak: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ep0OutNak && !wrNak && !clrDelayed[0] && !rxCountZero |=> ep0OutNak)
      else $error("out nak dropped without clear");
   a_rx_clear_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ep0RxClear && !outDataOk && !(wrNak && !nakSendingEp0RdEp2) |=> !ep0OutNak)
      else $error("rx clear kept out nak");
   a_in_ack_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      txAcked && !txBufFull && !shortDataEnd |=> !ep0InNak)
      else $error("in nak not cleared on ack");
   a_in_set_full: assert property (@(posedge ref_clk) disable iff (sys_rst)
      txBufFull || shortDataEnd |=> ep0InNak)
      else $error("in nak not set");
   a_upper_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_axi_rvalid |-> s_axi_rdata[31:2] == 30'h0)
      else $error("upper read bits not zero");
endmodule

// ### hw/uenak_pkg.sv
// Purpose: constants for the endpoint0 NAK control block
// Assumes: AXI4-Lite register access, 25 MHz ref_clk used as USB clock
// Notes: register map and timing counts live here
package uenak_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [15:0] ENDPOINT0_NAK_CONTROL_OFFS = 16'hFF60;
   localparam logic [15:0] FIFO_CLEAR_OFFS             = 16'hFF64;
   localparam logic [7:0]  NAK_CTRL_RESET              = 8'h00;
   localparam int          IN_NAK_BIT                  = 0;
   localparam int          OUT_NAK_BIT                 = 1;
   localparam int          FIFO_CLR_RX_BIT             = 0;
   localparam int          FIFO_CLR_TX_BIT             = 1;
   // ----------------------------------------
   // timing and axi response codes
   // ----------------------------------------
   localparam int          CLEAR_DELAY_CLKS            = 5;
   localparam logic [1:0]  RESP_OKAY                   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR                 = 2'h2;
endpackage

// ### hw/uenak_delay_line.sv
// Purpose: fixed-length delay of fifo-clear pulses
// Assumes: one clock domain
// Notes: all stages reset to zero
`timescale 1ns/100ps
module uenak_delay_line
   import uenak_pkg::*;
#(
   parameter int WIDTH = 2,
   parameter int DEPTH = CLEAR_DELAY_CLKS
)
(
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] dIn,
   output      logic [WIDTH-1:0] dOut
);
   logic [WIDTH-1:0] stage_ff [DEPTH];

   // shift register, one stage per clock
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : gStage
         always_ff @(posedge ref_clk or posedge sys_rst)
         begin
            if (sys_rst)
               stage_ff[g] <= '0;
            else if (g == 0)
               stage_ff[g] <= dIn;
            else
               stage_ff[g] <= stage_ff[(g == 0) ? 0 : g-1];
         end
      end
   endgenerate

   assign dOut = stage_ff[DEPTH-1];
endmodule

// ### testbench/uenak_host_model.sv
// Purpose: usb host side of endpoint0, as seen by the nak control
// Assumes: one event per call, driven right after a rising edge
// Notes: every event is a one-clock high pulse, then all lines go low
`timescale 1ns/100ps
module uenak_host_model
(
   input  wire logic ref_clk,
   output      logic outDataOk,
   output      logic txAcked,
   output      logic txBufFull,
   output      logic shortDataEnd
);
   initial {outDataOk, txAcked, txBufFull, shortDataEnd} = 4'h0;
   // code 0 out data, 1 ack, 2 buffer full, 3 short packet end
   task automatic ev(input logic [1:0] code);
      @(posedge ref_clk);
      case (code)
         2'h0: outDataOk <= 1'b1;
         2'h1: txAcked <= 1'b1;
         2'h2: txBufFull <= 1'b1;
         default: shortDataEnd <= 1'b1;
      endcase
      @(posedge ref_clk);
      {outDataOk, txAcked, txBufFull, shortDataEnd} <= 4'h0;
   endtask
endmodule

// ### testbench/uenak_ctrl_tb.sv
// Purpose: self-checking bench for the endpoint0 nak control
// Assumes: axi4-lite master with one transfer at a time
// Notes: fifo clear checks look once while the delayed clear is high, before the flag drops, and once after
`timescale 1ns/100ps
module uenak_ctrl_tb
   import uenak_pkg::*;
;
   logic        ref_clk, sys_rst, awValid, awReady, wValid, wReady, bValid, bReady;
   logic        arValid, arReady, rValid, rReady, rxCountZero, nakSend, autoReq;
   logic        outDataOk, txAcked, txBufFull, shortDataEnd;
   logic        nakReply, rxClr, txClr, outNak, inNak;
   logic [15:0] awAddr, arAddr;
   logic [3:0]  wStrb;
   logic [31:0] wData, rData, got;
   logic [1:0]  bResp, rResp, resp;
   int          mismatches, comparisons;
   uenak_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .outDataOk(outDataOk), .rxCountZero(rxCountZero), .txAcked(txAcked),
      .txBufFull(txBufFull), .shortDataEnd(shortDataEnd), .nakSendingEp0RdEp2(nakSend),
      .autoRequest(autoReq), .outNakReply(nakReply), .ep0RxClear(rxClr),
      .ep0TxClear(txClr), .ep0OutNak(outNak), .ep0InNak(inNak));
   uenak_host_model host (.ref_clk(ref_clk), .outDataOk(outDataOk), .txAcked(txAcked),
      .txBufFull(txBufFull), .shortDataEnd(shortDataEnd));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic nx(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // ready is sampled at the falling edge; inputs only move at rising edges
   task automatic wrc(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ha, hw, hb;
      int   n;
      n = 0;
      hb = 1'b0;
      @(posedge ref_clk);
      awAddr <= a;
      awValid <= 1'b1;
      wData <= {24'h000000, d};
      wValid <= 1'b1;
      bReady <= 1'b1;
      while (!hb && n < 64)
      begin
         @(negedge ref_clk);
         ha = awValid & awReady;
         hw = wValid & wReady;
         hb = bValid;
         resp = bResp;
         @(posedge ref_clk);
         if (ha) awValid <= 1'b0;
         if (hw) wValid <= 1'b0;
         n++;
      end
      bReady <= 1'b0;
      chk(hb === 1'b1 && resp === er, "write response");
   endtask
   task automatic rdc(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ha, hb;
      int   n;
      n = 0;
      hb = 1'b0;
      @(posedge ref_clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      while (!hb && n < 64)
      begin
         @(negedge ref_clk);
         ha = arValid & arReady;
         hb = rValid;
         got = rData;
         resp = rResp;
         @(posedge ref_clk);
         if (ha) arValid <= 1'b0;
         n++;
      end
      rReady <= 1'b0;
      chk(hb === 1'b1 && got === ed && resp === er, "read value");
   endtask
   task automatic close_out;
      if (mismatches == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ----------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // whole run is about a hundred cycles; this leaves ample slack
   initial
   begin
      repeat (4000) @(posedge ref_clk);
      mismatches++;
      close_out;
   end
   initial
   begin
      {awValid, wValid, bReady, arValid, rReady, rxCountZero, nakSend, autoReq} = 8'h00;
      {awAddr, arAddr, wData} = 64'h0;
      wStrb = 4'hF;
      sys_rst = 1'b1;
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rdc(ENDPOINT0_NAK_CONTROL_OFFS, 32'h0, RESP_OKAY);
      wrc(ENDPOINT0_NAK_CONTROL_OFFS, 8'hFF, RESP_OKAY);
      rdc(ENDPOINT0_NAK_CONTROL_OFFS, 32'h2, RESP_OKAY);
      chk(outNak === 1'b1 && nakReply === 1'b1, "forced nak");
      autoReq <= 1'b1;
      nx(1);
      chk(nakReply === 1'b0, "auto request");
      @(posedge ref_clk);
      autoReq <= 1'b0;
      wrc(ENDPOINT0_NAK_CONTROL_OFFS, 8'h00, RESP_OKAY);
      nx(1);
      chk(outNak === 1'b0 && nakReply === 1'b0, "firmware clear");
      @(posedge ref_clk);
      nakSend <= 1'b1;
      wrc(ENDPOINT0_NAK_CONTROL_OFFS, 8'h02, RESP_OKAY);
      rdc(ENDPOINT0_NAK_CONTROL_OFFS, 32'h0, RESP_OKAY);
      nakSend <= 1'b0;
      host.ev(2'h0);
      nx(1);
      chk(outNak === 1'b1, "out data sets");
      @(posedge ref_clk);
      rxCountZero <= 1'b1;
      @(posedge ref_clk);
      rxCountZero <= 1'b0;
      nx(1);
      chk(outNak === 1'b0, "count zero clears");
      host.ev(2'h0);
      wrc(FIFO_CLEAR_OFFS, 8'h01, RESP_OKAY);
      nx(4);
      chk(outNak === 1'b1 && rxClr === 1'b1, "clear settle");
      nx(1);
      chk(outNak === 1'b0, "rx clear");
      rdc(ENDPOINT0_NAK_CONTROL_OFFS, 32'h0, RESP_OKAY);
      host.ev(2'h2);
      rdc(ENDPOINT0_NAK_CONTROL_OFFS, 32'h1, RESP_OKAY);
      host.ev(2'h1);
      nx(1);
      chk(inNak === 1'b0, "ack clears");
      host.ev(2'h3);
      nx(1);
      chk(inNak === 1'b1, "short end sets");
      wrc(FIFO_CLEAR_OFFS, 8'h02, RESP_OKAY);
      nx(4);
      chk(txClr === 1'b1 && rxClr === 1'b0 && inNak === 1'b1, "tx clear settle");
      nx(2);
      chk(inNak === 1'b0 && outNak === 1'b0 && txClr === 1'b0, "tx clear");
      rdc(16'h0000, 32'h0, RESP_SLVERR);
      wrc(16'h0000, 8'h02, RESP_SLVERR);
      rdc(FIFO_CLEAR_OFFS, 32'h0, RESP_OKAY);
      // byte lane 0 strobe low: the write is answered but changes nothing
      wStrb <= 4'hE;
      wrc(ENDPOINT0_NAK_CONTROL_OFFS, 8'h02, RESP_OKAY);
      rdc(ENDPOINT0_NAK_CONTROL_OFFS, 32'h0, RESP_OKAY);
      wStrb <= 4'hF;
      close_out;
   end
endmodule
